/* verilog/tcm_pkg.sv */
// constants, field layout and carrier types of the timer channel-mode block
package tcm_pkg;
    // register byte offsets on the apb window
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_SWEVT  = 8'h14;
    localparam logic [7:0] OFS_CTRL_A = 8'h18;
    localparam logic [7:0] OFS_CTRL_B = 8'h1c;
    localparam logic [7:0] OFS_ENABLE = 8'h20;
    localparam logic [7:0] OFS_CMP1   = 8'h34;
    localparam logic [7:0] CMP_STEP   = 8'h04;
    // reset values
    localparam logic [15:0] RST_CTRL  = 16'h0000;
    localparam logic [15:0] RST_CMP   = 16'h0000;
    localparam logic [15:0] RST_EN    = 16'h0000;
    // channel count and per-byte field positions of the mode registers
    localparam int CH_N       = 4;
    localparam int F_CLR      = 7;
    localparam int F_MODE     = 4;
    localparam int F_PRE      = 3;
    localparam int F_FAST     = 2;
    localparam int F_DIR      = 0;
    localparam int F_FLT      = 4;
    localparam int F_PSC      = 2;
    // enable register: one bit per channel, four bits apart
    localparam int EN_STRIDE  = 4;
    // software event register bits
    localparam int SW_UPD     = 0;
    localparam int SW_CH      = 1;
    localparam int SW_W       = 5;
    // status register bits
    localparam int ST_UPD     = 0;
    localparam int ST_EVT     = 1;
    localparam int ST_OVR     = 9;
    // write-protection level that freezes output mode bits
    localparam logic [1:0] LOCK_FULL = 2'h3;
    // input filter codes and their sample counts minus one
    localparam logic [3:0] FLT_NONE  = 4'h0;
    localparam logic [3:0] FLT_N2    = 4'h1;
    localparam logic [3:0] FLT_N4    = 4'h2;
    localparam logic [2:0] LIM_NONE  = 3'h0;
    localparam logic [2:0] LIM_N2    = 3'h1;
    localparam logic [2:0] LIM_N4    = 3'h3;
    localparam logic [2:0] LIM_OTHER = 3'h7;

    typedef enum logic [2:0] {
        OM_FROZEN   = 3'h0,
        OM_MATCH_HI = 3'h1,
        OM_MATCH_LO = 3'h2,
        OM_TOGGLE   = 3'h3,
        OM_FORCE_LO = 3'h4,
        OM_FORCE_HI = 3'h5,
        OM_PWM1     = 3'h6,
        OM_PWM2     = 3'h7
    } tcm_omode_t;

    typedef enum logic [1:0] {
        DIR_OUT   = 2'h0,
        DIR_OWN   = 2'h1,
        DIR_NEIGH = 2'h2,
        DIR_TRIG  = 2'h3
    } tcm_dir_t;

    // live view of the counter core
    typedef struct packed {
        logic [15:0] value;   // current count
        logic        tick;    // count advanced this cycle
        logic        down;    // counting down
        logic        center;  // center-aligned mode
        logic [15:0] reload;  // auto-reload value
    } tcm_cnt_t;

    // reinit command to the counter core and prescaler
    typedef struct packed {
        logic        reinit;     // one-cycle reinit pulse
        logic        psc_clear;  // clear prescaler count, keep ratio
        logic [15:0] load;       // value the counter takes
    } tcm_upd_t;
endpackage

/* verilog/tcm_in_chan.sv */
// capture input conditioning: digital filter, edge detect and capture prescaler
`timescale 1ns/1ps
module tcm_in_chan #(
    parameter int CW = 3 // width of the filter run counter
) (
    input  wire logic       clk,   // timer clock
    input  wire logic       rstn,  // synchronous reset, active low
    input  wire logic       sig,   // selected channel input
    input  wire logic       en,    // channel capture enable
    input  wire logic [3:0] flt,   // filter code
    input  wire logic [1:0] psc,   // capture prescale code
    output logic            cap_r  // one-cycle capture request
);
    import tcm_pkg::*;

    logic          lvl_r;  // filtered level
    logic [CW-1:0] run_r;  // differing samples seen against lvl_r
    logic [2:0]    div_r;  // events counted toward a capture
    logic [CW-1:0] lim;    // samples needed minus one
    logic [2:0]    mask;   // events per capture minus one
    logic          rise;   // filtered rising edge

    // codes above four samples all take eight at the timer clock
    always_comb begin
        if (flt == FLT_NONE) begin
            lim = CW'(LIM_NONE);
        end else if (flt == FLT_N2) begin
            lim = CW'(LIM_N2);
        end else if (flt == FLT_N4) begin
            lim = CW'(LIM_N4);
        end else begin
            lim = CW'(LIM_OTHER);
        end
    end

    assign mask = {psc == 2'h3, psc[1], psc != 2'h0};
    assign rise = sig && !lvl_r && (run_r == lim);

    // level passes only after a run of equal samples
    always_ff @(posedge clk) begin
        if (!rstn) begin
            lvl_r <= 1'b0;
            run_r <= '0;
        end else if (sig == lvl_r) begin
            run_r <= '0;              // glitch resets the run
        end else if (run_r == lim) begin
            lvl_r <= sig;
            run_r <= '0;
        end else begin
            run_r <= run_r + 1'b1;
        end
    end

    // capture on every 1, 2, 4 or 8 edges; cleared with the enable
    always_ff @(posedge clk) begin
        if (!rstn || !en) begin
            div_r <= 3'h0;
            cap_r <= 1'b0;
        end else begin
            cap_r <= 1'b0;
            if (rise) begin
                if (div_r == mask) begin
                    cap_r <= 1'b1;
                    div_r <= 3'h0;
                end else begin
                    div_r <= div_r + 3'h1;
                end
            end
        end
    end
endmodule // tcm_in_chan

/* verilog/tcm_chan_ctrl.sv */
// channel mode control, compare reference, capture and software events
`timescale 1ns/1ps
module tcm_chan_ctrl (
    input  wire logic             clk,             // 20 MHz timer clock
    input  wire logic             rstn,            // synchronous reset, active low
    input  wire logic             psel,            // apb select
    input  wire logic             penable,         // apb access phase
    input  wire logic             pwrite,          // apb write
    input  wire logic [7:0]       paddr,           // apb byte address
    input  wire logic [31:0]      pwdata,          // apb write data
    output logic      [31:0]      prdata_r,        // apb read data
    output logic                  pready_r,        // apb ready
    output logic                  pslverr_r,       // apb error, unmapped
    input  wire tcm_pkg::tcm_cnt_t cnt,            // counter core view
    input  wire logic             update_in,       // update from counter core
    input  wire logic [3:0]       pin_in,          // channel pins, synchronous
    input  wire logic             internal_trigger_input, // internal trigger
    input  wire logic             trig_selected,   // an internal trigger is chosen
    input  wire logic             trig_edge,       // valid trigger edge pulse
    input  wire logic             filtered_ext_trigger, // filtered ext trigger
    input  wire logic [1:0]       lock_level,      // write-protection level
    output logic      [3:0]       ch_reference_r,  // output references
    output logic      [3:0]       ch_event_r,      // flag-set pulse, to irq/dma
    output logic                  update_event_r,  // update pulse
    output tcm_pkg::tcm_upd_t     upd_cmd_r        // reinit command
);
    import tcm_pkg::*;

    logic [15:0]      ctrl_r [2];      // mode registers a and b
    logic [15:0]      en_r;            // channel enables
    logic [15:0]      pre_r [CH_N];    // compare preload copies
    logic [15:0]      shd_r [CH_N];    // compare shadows
    logic [CH_N-1:0]  flag_r;          // channel event flags
    logic [CH_N-1:0]  ovr_r;           // overcapture flags
    logic             upd_flag_r;      // update flag
    logic [SW_W-1:0]  sw_r;            // software event pulses
    logic [CH_N-1:0]  gt_prev_r;       // last compare result
    logic [CH_N-1:0]  was_frozen_r;    // previous mode was frozen
    logic [CH_N-1:0]  cap_pulse;       // filtered capture requests
    logic [CH_N-1:0]  ch_set;          // flag set this cycle
    logic [CH_N-1:0]  ovr_set;         // overcapture set this cycle
    logic [CH_N-1:0]  rd_clr;          // compare read in input mode
    logic [CH_N-1:0]  ref_nxt;         // next references
    logic [CH_N-1:0]  gt;              // counter above active compare
    logic [CH_N-1:0]  cap_now;         // capture this cycle
    logic             acc;             // first access cycle
    logic             commit;          // completing transfer edge
    logic             wr;              // write takes effect now
    logic [31:0]      rd_nxt;          // read mux
    logic             map_ok;          // address is mapped
    logic             upd_any;         // any update event

    // channel byte of a mode register
    function automatic logic [7:0] ch_byte(input logic [15:0] r, input int i);
        ch_byte = r[8*(i%2) +: 8];
    endfunction

    // merge a written byte with the protections on direction and mode
    function automatic logic [7:0] ch_merge(input logic [7:0] old,
                                            input logic [7:0] nw,
                                            input logic       en,
                                            input logic [1:0] lock);
        logic [7:0] m;
        m = nw;
        if (en) begin
            m[F_DIR +: 2] = old[F_DIR +: 2];
        end
        if (lock == LOCK_FULL && old[F_DIR +: 2] == DIR_OUT) begin
            m[F_MODE +: 3] = old[F_MODE +: 3];
            m[F_PRE] = old[F_PRE];
        end
        ch_merge = m;
    endfunction

    assign acc    = psel && penable && !pready_r;
    assign commit = psel && penable && pready_r;
    assign wr     = commit && pwrite && !pslverr_r;
    assign upd_any = sw_r[SW_UPD] || update_in;

    // read mux; decoding also flags unmapped addresses
    always_comb begin
        rd_nxt = 32'h0000_0000;
        map_ok = 1'b1;
        if (paddr == OFS_STATUS) begin
            rd_nxt = {19'h0, ovr_r, 4'h0, flag_r, upd_flag_r};
        end else if (paddr == OFS_SWEVT) begin
            rd_nxt = 32'h0000_0000;                  // write-only, reads zero
        end else if (paddr == OFS_CTRL_A) begin
            rd_nxt = {16'h0, ctrl_r[0]};
        end else if (paddr == OFS_CTRL_B) begin
            rd_nxt = {16'h0, ctrl_r[1]};
        end else if (paddr == OFS_ENABLE) begin
            rd_nxt = {16'h0, en_r};
        end else if (paddr >= OFS_CMP1 && paddr <= OFS_CMP1 + 8'(3 * CMP_STEP)
                     && paddr[1:0] == 2'h0) begin
            rd_nxt = {16'h0, pre_r[2'(paddr[3:2] - OFS_CMP1[3:2])]};
        end else begin
            map_ok = 1'b0;
        end
    end

    // apb slave: one wait state, data and error registered
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= acc;
            if (acc) begin
                prdata_r  <= pwrite ? 32'h0000_0000 : rd_nxt;
                pslverr_r <= !map_ok;
            end else begin
                pslverr_r <= 1'b0;
            end
        end
    end

    // mode registers, byte by byte through the protections
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_r[0] <= RST_CTRL;
            ctrl_r[1] <= RST_CTRL;
        end else if (wr && (paddr == OFS_CTRL_A || paddr == OFS_CTRL_B)) begin
            for (int j = 0; j < CH_N; j++) begin
                if ((j / 2) == int'(paddr == OFS_CTRL_B)) begin
                    ctrl_r[j / 2][8*(j%2) +: 8] <= ch_merge(
                        ch_byte(ctrl_r[j / 2], j), pwdata[8*(j%2) +: 8],
                        en_r[EN_STRIDE*j], lock_level);
                end
            end
        end
    end

    // channel enable register
    always_ff @(posedge clk) begin
        if (!rstn) begin
            en_r <= RST_EN;
        end else if (wr && paddr == OFS_ENABLE) begin
            en_r <= pwdata[15:0];
        end
    end

    // software events live one cycle, then hardware drops them
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sw_r <= '0;
        end else if (wr && paddr == OFS_SWEVT) begin
            sw_r <= pwdata[SW_W-1:0];                // a zero bit does nothing
        end else begin
            sw_r <= '0;
        end
    end

    // software update: reinit counter and clear prescaler count
    always_ff @(posedge clk) begin
        if (!rstn) begin
            upd_cmd_r      <= '0;
            update_event_r <= 1'b0;
        end else begin
            upd_cmd_r.reinit    <= sw_r[SW_UPD];
            upd_cmd_r.psc_clear <= sw_r[SW_UPD];
            if (sw_r[SW_UPD]) begin
                upd_cmd_r.load <= (cnt.down && !cnt.center) ? cnt.reload
                                                            : 16'h0000;
            end
            update_event_r <= upd_any;
        end
    end

    // update flag: set wins over a software clear
    always_ff @(posedge clk) begin
        if (!rstn) begin
            upd_flag_r <= 1'b0;
        end else if (upd_any) begin
            upd_flag_r <= 1'b1;
        end else if (wr && paddr == OFS_STATUS && !pwdata[ST_UPD]) begin
            upd_flag_r <= 1'b0;
        end
    end

    genvar g;
    generate
        for (g = 0; g < CH_N; g++) begin : g_ch
            logic [7:0]  cb;      // this channel's control byte
            logic [1:0]  dir;     // direction field
            logic [2:0]  mode;    // output mode
            logic        is_out;  // channel is an output
            logic        pwm;     // pwm mode active
            logic        eq;      // compare match on a count step
            logic        src;     // selected input source
            logic        lvl;     // pwm level from the comparison
            logic [15:0] act;     // compare value in use
            logic [7:0]  cmp_ofs; // this channel's compare offset

            assign cb      = ch_byte(ctrl_r[g / 2], g);
            assign dir     = cb[F_DIR +: 2];
            assign mode    = cb[F_MODE +: 3];
            assign is_out  = dir == DIR_OUT;
            assign pwm     = mode == OM_PWM1 || mode == OM_PWM2;
            assign act     = cb[F_PRE] ? shd_r[g] : pre_r[g];
            assign gt[g]   = cnt.value > act;
            assign eq      = cnt.tick && cnt.value == act;
            assign cmp_ofs = OFS_CMP1 + 8'(g * CMP_STEP);
            // pwm2 simply inverts pwm1 in both directions
            assign lvl = (cnt.down ? gt[g] : !gt[g]) ^ (mode == OM_PWM2);

            // input source: own pin, neighbour pin or internal trigger
            always_comb begin
                if (dir == DIR_OWN) begin
                    src = pin_in[g];
                end else if (dir == DIR_NEIGH) begin
                    src = pin_in[g ^ 1];
                end else begin
                    // trigger source only counts when one is selected
                    src = (dir == DIR_TRIG) && trig_selected && internal_trigger_input;
                end
            end

            tcm_in_chan u_in (
                .clk   (clk),
                .rstn  (rstn),
                .sig   (src),
                .en    (en_r[EN_STRIDE*g] && !is_out),
                .flt   (cb[F_FLT +: 4]),
                .psc   (cb[F_PSC +: 2]),
                .cap_r (cap_pulse[g])
            );

            // a software event on an input captures as well
            assign cap_now[g] = !is_out && (sw_r[SW_CH + g] || cap_pulse[g]);
            assign ch_set[g]  = sw_r[SW_CH + g] || (is_out ? eq : cap_now[g]);
            assign ovr_set[g] = cap_now[g] && flag_r[g];
            assign rd_clr[g]  = commit && !pwrite && paddr == cmp_ofs && !is_out;

            // next reference level
            always_comb begin
                ref_nxt[g] = ch_reference_r[g];
                if (!is_out) begin
                    ref_nxt[g] = 1'b0;
                end else if (cb[F_CLR] && filtered_ext_trigger) begin
                    ref_nxt[g] = 1'b0;
                end else begin
                    case (mode)
                        OM_FROZEN:   ref_nxt[g] = ch_reference_r[g];
                        OM_MATCH_HI: if (eq) ref_nxt[g] = 1'b1;
                        OM_MATCH_LO: if (eq) ref_nxt[g] = 1'b0;
                        OM_TOGGLE:   if (eq) ref_nxt[g] = !ch_reference_r[g];
                        OM_FORCE_LO: ref_nxt[g] = 1'b0;
                        OM_FORCE_HI: ref_nxt[g] = 1'b1;
                        default: begin
                            if (cb[F_FAST] && trig_edge) begin
                                ref_nxt[g] = 1'b1;
                            end else if (gt[g] != gt_prev_r[g] || was_frozen_r[g]) begin
                                ref_nxt[g] = lvl;
                            end
                        end
                    endcase
                end
            end

            // reference and the history that pwm mode looks at
            always_ff @(posedge clk) begin
                if (!rstn) begin
                    ch_reference_r[g] <= 1'b0;
                    gt_prev_r[g]      <= 1'b0;
                    was_frozen_r[g]   <= 1'b1;
                end else begin
                    ch_reference_r[g] <= ref_nxt[g];
                    gt_prev_r[g]      <= gt[g];
                    was_frozen_r[g]   <= mode == OM_FROZEN;
                end
            end

            // compare value: capture beats software, update loads the shadow
            always_ff @(posedge clk) begin
                if (!rstn) begin
                    pre_r[g] <= RST_CMP;
                    shd_r[g] <= RST_CMP;
                end else if (cap_now[g]) begin
                    pre_r[g] <= cnt.value;
                    shd_r[g] <= cnt.value;
                end else begin
                    if (wr && paddr == cmp_ofs) begin
                        pre_r[g] <= pwdata[15:0];
                    end
                    if (upd_any) begin
                        shd_r[g] <= pre_r[g];
                    end
                end
            end

            // flags: set wins over the write-zero clear and the read clear
            always_ff @(posedge clk) begin
                if (!rstn) begin
                    flag_r[g]     <= 1'b0;
                    ovr_r[g]      <= 1'b0;
                    ch_event_r[g] <= 1'b0;
                end else begin
                    ch_event_r[g] <= ch_set[g];
                    if (ch_set[g]) begin
                        flag_r[g] <= 1'b1;
                    end else if ((wr && paddr == OFS_STATUS && !pwdata[ST_EVT + g])
                                 || rd_clr[g]) begin
                        flag_r[g] <= 1'b0;
                    end
                    if (ovr_set[g]) begin
                        ovr_r[g] <= 1'b1;
                    end else if (wr && paddr == OFS_STATUS && !pwdata[ST_OVR + g]) begin
                        ovr_r[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate
endmodule // tcm_chan_ctrl

/* sim/tcm_chk_checker.sv */
// port assertions for the channel-mode block
`timescale 1ns/1ps
module tcm_chk (
    input wire logic              clk,                  // clock
    input wire logic              rstn,                 // reset, low
    input wire logic              psel,                 // apb
    input wire logic              penable,              // apb
    input wire logic              pwrite,               // apb
    input wire logic [7:0]        paddr,                // apb
    input wire logic [31:0]       pwdata,               // apb
    input wire logic              pready_r,             // apb
    input wire tcm_pkg::tcm_cnt_t cnt,                  // counter
    input wire logic              filtered_ext_trigger, // clear
    input wire logic [3:0]        ch_reference_r,       // refs
    input wire logic [3:0]        ch_event_r,           // flag pulses
    input wire logic              update_event_r,       // update
    input wire tcm_pkg::tcm_upd_t upd_cmd_r             // reinit
);
    import tcm_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic       ws;  // committed write to the event register
    logic [7:0] m_r; // channel-0 byte copy; the bench keeps lock tests off it
    assign ws = psel && penable && pready_r && pwrite && paddr == OFS_SWEVT;
    // follow committed writes to mode register a
    always_ff @(posedge clk) begin
        if (!rstn) m_r <= 8'h00;
        else if (psel && penable && pready_r && pwrite && paddr == OFS_CTRL_A) m_r <= pwdata[7:0];
    end
    sw_event_a: assert property (ws && pwdata[1] |-> ##[2:3] ch_event_r[0])
        else $error("sw event gave no pulse");
    sw_update_a: assert property (ws && pwdata[0] |-> ##[2:3] update_event_r)
        else $error("sw update gave no pulse");
    upd_load_a: assert property (upd_cmd_r.reinit |-> upd_cmd_r.psc_clear &&
        upd_cmd_r.load == (cnt.down && !cnt.center ? cnt.reload : 16'h0000))
        else $error("bad reinit load");
    upd_once_a: assert property (update_event_r |=> !update_event_r)
        else $error("update pulse stuck");
    force_lo_a: assert property ((m_r[6:0] == 7'h40)[*2] |-> !ch_reference_r[0])
        else $error("force low not low");
    force_hi_a: assert property ((m_r == 8'h50)[*2] |-> ch_reference_r[0])
        else $error("force high not high");
    frozen_ref_a: assert property ((m_r[7:4] == 4'h0 && m_r[1:0] == 2'h0)[*2]
        |-> $stable(ch_reference_r[0])) else $error("frozen ref moved");
    ext_clear_a: assert property ((m_r[7] && m_r[1:0] == 2'h0 && filtered_ext_trigger)[*2]
        |-> !ch_reference_r[0]) else $error("clear did not pull low");
endmodule // tcm_chk
bind tcm_chan_ctrl tcm_chk u_chk (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready_r, .cnt, .filtered_ext_trigger, .ch_reference_r, .ch_event_r, .update_event_r,
    .upd_cmd_r);

/* sim/tcm_pins.sv */
// pin-side model: channel pin sources and the external clear trigger
`timescale 1ns/1ps
module tcm_pins (
    input wire logic  clk,     // timer clock
    output logic [3:0] pin_in, // channel pin levels
    output logic       ext_trig // clear trigger level
);
    initial begin
        pin_in = 4'h0;
        ext_trig = 1'b0;
    end
    // n rising edges; each level held five clocks so short filters pass it
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clk) pin_in <= 4'hf;
            repeat (5) @(posedge clk);
            pin_in <= 4'h0;
            repeat (5) @(posedge clk);
        end
    endtask
    task automatic clr(input logic lv);
        @(posedge clk) ext_trig <= lv;
    endtask
endmodule // tcm_pins

/* sim/tcm_chan_ctrl_tb.sv */
// self-checking bench for the channel-mode block
`timescale 1ns/1ps
module tcm_chan_ctrl_tb;
    import tcm_pkg::*;
    logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        trig_edge = 1'b0, pready_r, pslverr_r, ext, e, ue; // ext: clear trigger
    logic [1:0]  lock_level = 2'h0;    // write protection
    logic [3:0]  pin_in, ch_reference_r, ev; // pins in, references and flag pulses out
    logic [7:0]  paddr = 8'h00;        // apb address
    logic [15:0] v;                    // random draw
    logic [31:0] pwdata = '0, prdata_r, q, seed = 32'h9cf7; // q: last read
    tcm_cnt_t    cnt = '0;             // counter core view
    int          fails = 0, n_tests = 0;
    initial forever #25 clk = ~clk;
    tcm_chan_ctrl dut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_r,
        .pready_r, .pslverr_r, .cnt, .update_in(1'b0), .pin_in, .internal_trigger_input(1'b0),
        .trig_selected(1'b0), .trig_edge, .filtered_ext_trigger(ext), .lock_level,
        .ch_reference_r, .ch_event_r(ev), .update_event_r(ue), .upd_cmd_r());
    tcm_pins pins (.clk, .pin_in, .ext_trig(ext));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // pwm level: mode 6 active at or below compare counting up, mode 7 inverted
    function automatic logic pwm_ref(logic m2, logic dn, logic [15:0] c, logic [15:0] k);
        return m2 ^ ((c > k) == dn);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        if (fails == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one transfer; an edge passes first so release and next setup never collide
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk) penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready_r !== 1'b1 && n < 20);
        if (pready_r !== 1'b1) fails++;
        q = prdata_r;
        e = pslverr_r;
        {psel, penable} <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        apb(1'b1, a, {16'h0, d});
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q, x);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        wrap_up();
    end
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        rdc(OFS_CTRL_A, 32'h0);
        rdc(OFS_CTRL_B, 32'h0);
        apb(1'b0, 8'h44, 32'h0);
        chk(e, 1'b1);
        for (int i = 0; i < 8; i++) begin
            v = 16'(rnd());
            wr(i[0] ? OFS_CTRL_B : OFS_CTRL_A, v);
            rdc(i[0] ? OFS_CTRL_B : OFS_CTRL_A, {16'h0, v});
        end
        wr(OFS_CTRL_A, 16'h0);
        wr(OFS_STATUS, 16'h0);
        wr(OFS_SWEVT, 16'h0);
        rdc(OFS_STATUS, 32'h0);
        wr(OFS_SWEVT, 16'h2);
        repeat (2) @(posedge clk);
        chk(ev, 4'h1);
        rdc(OFS_STATUS, 32'h2);
        rdc(OFS_SWEVT, 32'h0);
        v = 16'(rnd());
        cnt.value <= v;
        wr(OFS_CTRL_A, 16'h1);
        wr(OFS_ENABLE, 16'h1);
        wr(OFS_STATUS, 16'h0);
        wr(OFS_SWEVT, 16'h2);
        wr(OFS_SWEVT, 16'h2);
        rdc(OFS_STATUS, 32'h202);
        rdc(OFS_CMP1, {16'h0, v});
        // every prescale code: one edge short of the ratio, then the edge that captures
        for (int p = 0; p < 4; p++) begin
            wr(OFS_ENABLE, 16'h0);
            wr(OFS_CTRL_A, {12'h0, p[1:0], 2'h1});
            wr(OFS_ENABLE, 16'h1);
            wr(OFS_STATUS, 16'h0);
            pins.pulses((1 << p) - 1);
            rdc(OFS_STATUS, 32'h0);
            pins.pulses(1);
            rdc(OFS_STATUS, 32'h2);
        end
        wr(OFS_ENABLE, 16'h0);
        wr(OFS_CTRL_A, 16'h0);
        lock_level <= LOCK_FULL;
        wr(OFS_CTRL_A, 16'h7800);
        rdc(OFS_CTRL_A, 32'h0);
        lock_level <= 2'h0;
        wr(OFS_CTRL_A, 16'h0100);
        wr(OFS_ENABLE, 16'h0010);
        wr(OFS_CTRL_A, 16'h0);
        rdc(OFS_CTRL_A, 32'h0100);
        wr(OFS_CMP1, 16'h0100);
        wr(OFS_SWEVT, 16'h1); // shadow still holds the capture, load it
        cnt.tick <= 1'b1;
        // each pwm mode, both directions, both sides of compare; preload on
        for (int i = 0; i < 8; i++) begin
            {cnt.down, cnt.value} <= {i[1], i[0] ? 16'h0200 : 16'h0080};
            wr(OFS_CTRL_A, 16'h0);
            wr(OFS_CTRL_A, i[2] ? 16'h0078 : 16'h0068);
            repeat (2) @(posedge clk);
            chk(ch_reference_r[0], pwm_ref(i[2], i[1], cnt.value, 16'h0100));
        end
        wr(OFS_CTRL_A, 16'h0);
        cnt.down <= 1'b0;
        wr(OFS_CTRL_A, 16'h006c);
        @(posedge clk) trig_edge <= 1'b1;
        @(posedge clk) trig_edge <= 1'b0;
        @(posedge clk) chk(ch_reference_r[0], 1'b1);
        wr(OFS_CTRL_A, 16'h0050);
        wr(OFS_CTRL_A, 16'h0040);
        wr(OFS_CTRL_A, 16'h00d0);
        pins.clr(1'b1);
        repeat (3) @(posedge clk);
        chk(ch_reference_r[0], 1'b0);
        pins.clr(1'b0);
        {cnt.down, cnt.reload} <= {1'b1, 16'(rnd())};
        wr(OFS_STATUS, 16'h0);
        wr(OFS_SWEVT, 16'h1);
        repeat (2) @(posedge clk);
        chk(ue, 1'b1);
        rdc(OFS_STATUS, 32'h1);
        wrap_up();
    end
endmodule // tcm_chan_ctrl_tb
